/* hw/cfm_params.svh */
// Constants for the frame mailbox: register map, frame codes, status bits.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define CFM_PTR_STATUS 8'h00
`define CFM_BUF_FIRST 8'h07
`define CFM_BUF_LAST 8'h19
`define CFM_BUF_DEPTH 19
`define CFM_MAX_PARAMS 5'd17
`define CFM_MIN_LEN 8'h03
`define CFM_PTR_RESET 8'h00
// ------------------------------------------------------------
// Frame codes
// ------------------------------------------------------------
`define CFM_SVC_REQ 8'h00
`define CFM_SVC_CNF 8'h01
`define CFM_SVC_IND 8'h81
`define CFM_SVC_ERR 8'h82
`define CFM_SVC_IER 8'h83
`define CFM_RES_OFF 8'h80
`define CFM_RES_BAD 8'h81
`define CFM_RD_FILL 8'hff
`define CFM_RD_EMPTY 8'h00
`define CFM_LEN_CNF 8'h03
`define CFM_LEN_ERR 8'h02
// ------------------------------------------------------------
// Status register bits, host bus address and transmit FIFO depth
// ------------------------------------------------------------
`define CFM_STAT_BUSY 7
`define CFM_STAT_INT 6
`define CFM_I2C_ADDR 7'h34
`define CFM_FIFO_DEPTH 8
`endif

/* hw/cfm_pkg.sv */
// Types shared by the frame mailbox design files.
// Assumes cfm_params.svh is on the include path.
`include "cfm_params.svh"
package cfm_pkg;
  // Byte of a line message with its end marker
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } cfm_byte_t;
  // Buffer ownership states
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_SEND, ST_WAIT, ST_OUT
  } cfm_state_t;
  // Host serial bus phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_WDATA, PH_ACK, PH_RDATA, PH_MACK
  } cfm_phase_t;
endpackage

/* hw/cfm_top.sv */
// Frame mailbox: host serial slave, 19-byte frame buffer, transmit FIFO.
// Assumes a line engine on clk_sys that sends bytes, returns result codes
// and delivers received messages; it also enforces signal free time.
// Operation
// - Nineteen byte buffer at 07h to 19h
// - Host masters transfers; interrupt flags waiting frame
// - Pointer loaded first, advances per byte
// - Frames start only at 07h, whole
// - Length, service code, up to 17 parameters
// - Frames never exceed 19 bytes
// - Only one outstanding transmit request
// - Reads beyond 19h or length give FFh
// - Unknown service answered with result 81h
// - All service parameters mandatory, none optional
// - First parameter holds source and destination nibbles
// - Send only after complete frame arrives
// - Confirm each request with its result code
// - Received messages delivered as indication frames
// - Error notice only when reporting enabled
// - Receive-with-error only when reporting enabled
// - First written byte loads pointer, rest stored
// - Frame contents moved as contiguous ranges
// - Pointer at 00h never advances on read
// - Request code 00h, confirmation code 01h
// - Indication frames use service code 81h
// - Short host write discarded, no confirmation
// - Interrupt drops on last read or abort
`timescale 1ns/100ps
`include "cfm_params.svh"

// ------------------------------------------------------------
// Shift-register FIFO with registered head and flags
// ------------------------------------------------------------
module cfm_fifo #(
  parameter int W = 9,
  parameter int D = `CFM_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_r [0:D-1]; // Entry 0 is the head
  logic [CW-1:0] cnt_r; // Entries held
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] wpos; // Slot taken by a push
  logic push;
  logic pop;
  logic in_ready_r;
  logic out_valid_r;

  assign push = in_valid & in_ready_r;
  assign pop = out_valid_r & out_ready;
  assign wpos = cnt_r - CW'(pop);
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem_r[0];

  // Storage: pop shifts toward the head, push fills the next free slot
  for (genvar g = 0; g < D; g++) begin : g_ent
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        mem_r[g] <= '0;
      end else if (push && wpos == CW'(g)) begin
        mem_r[g] <= in_data;
      end else if (pop && g < D - 1) begin
        mem_r[g] <= mem_r[(g < D - 1) ? g + 1 : g];
      end
    end
  end

  // Occupancy and flags, registered so the ports are flops
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_r <= '0;
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt != CW'(D));
      out_valid_r <= (cnt_nxt != '0);
    end
  end
endmodule // cfm_fifo

// ------------------------------------------------------------
// Top: serial slave, pointer, frame buffer and services
// ------------------------------------------------------------
module cfm_top #(
  parameter logic [6:0] DEV_ADDR = `CFM_I2C_ADDR,
  parameter int FIFO_DEPTH = `CFM_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq,
  input wire logic line_on,
  input wire logic err_rpt_en,
  output cfm_pkg::cfm_byte_t tx_out,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic res_valid,
  input wire logic [7:0] res_code,
  input wire cfm_pkg::cfm_byte_t rx_in,
  input wire logic rx_err,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic err_evt
);
  import cfm_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [1:0] rst_q; // Reset release chain
  logic rst_sync_n;
  logic [2:0] scl_s; // Pin samplers
  logic [2:0] sda_s;
  logic scl_f, sda_f; // Agreed levels
  logic scl_q, sda_q; // Previous agreed levels
  logic scl_rise, scl_fall, start_ev, stop_ev;
  cfm_phase_t ph_r; // Serial phase
  logic [3:0] cnt_r; // Bit count
  logic [7:0] sh_r; // Receive shifter
  logic [7:0] tx_sh_r; // Transmit shifter
  logic rw_r; // Read transaction
  logic first_r; // Next written byte is the pointer
  logic mack_r; // Master acked last read byte
  logic sda_oe_r;
  logic wr_ev, rd_load_ev, rd_done_ev;
  logic [7:0] ptr_r; // Register pointer
  logic buf_touched_r; // Buffer written this transaction
  logic [7:0] buf_r [0:`CFM_BUF_DEPTH-1]; // Frame buffer
  cfm_state_t st_r;
  logic [4:0] hw_cnt_r; // Contiguous host bytes written
  logic [4:0] idx_r; // Send index
  logic [4:0] rx_cnt_r; // Received bytes stored
  logic [4:0] bidx; // Buffer index of pointer
  logic in_buf;
  logic [7:0] len; // Announced frame length
  logic buf_wr, wr_done, rx_take, err_take;
  logic err_pend_r;
  logic rd_started_r;
  logic irq_r, rx_ready_r;
  logic [7:0] rd_byte;
  logic push_last;
  cfm_byte_t push_data;
  logic fifo_in_ready;

  // ------------------------------------------------------------
  // Reset release and pin sampling
  // ------------------------------------------------------------
  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_q[1];

  // Three-flop samplers; a level counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      if (scl_s[1] == scl_s[2]) begin
        scl_f <= scl_s[2];
      end
      if (sda_s[1] == sda_s[2]) begin
        sda_f <= sda_s[2];
      end
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_ev = scl_f & scl_q & ~sda_q & sda_f;

  // ------------------------------------------------------------
  // Serial slave
  // ------------------------------------------------------------
  assign wr_ev = (ph_r == PH_WDATA) && scl_fall && (cnt_r == 4'h8);
  assign rd_load_ev = scl_fall && (((ph_r == PH_ACK) && rw_r) || ((ph_r == PH_MACK) && mack_r));
  assign rd_done_ev = (ph_r == PH_MACK) && scl_rise;

  // Bit engine; the host always masters, the device only answers
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ph_r <= PH_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      ph_r <= PH_ADDR; // Start or repeated start
      cnt_r <= 4'h0;
      first_r <= 1'b1;
      sda_oe_r <= 1'b0;
    end else if (stop_ev) begin
      ph_r <= PH_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (ph_r)
        PH_ADDR, PH_WDATA: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_f};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (ph_r == PH_WDATA) begin
              sda_oe_r <= 1'b1; // Ack every data byte
              ph_r <= PH_ACK;
            end else if (sh_r[7:1] == DEV_ADDR) begin
              sda_oe_r <= 1'b1; // Ack our address
              rw_r <= sh_r[0];
              ph_r <= PH_ACK;
            end else begin
              ph_r <= PH_IDLE; // Not ours
            end
          end
          if (wr_ev) begin
            first_r <= 1'b0;
          end
        end
        PH_ACK, PH_MACK: begin
          if (scl_rise && ph_r == PH_MACK) begin
            mack_r <= ~sda_f; // Low means more wanted
          end
          if (rd_load_ev) begin
            sda_oe_r <= ~rd_byte[7];
            tx_sh_r <= {rd_byte[6:0], 1'b0};
            cnt_r <= 4'h1;
            ph_r <= PH_RDATA;
          end else if (scl_fall) begin
            sda_oe_r <= 1'b0;
            ph_r <= (ph_r == PH_ACK) ? PH_WDATA : PH_IDLE;
          end
        end
        PH_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              sda_oe_r <= 1'b0; // Release for master ack
              ph_r <= PH_MACK;
            end else begin
              sda_oe_r <= ~tx_sh_r[7];
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register pointer
  // ------------------------------------------------------------
  // Load, advance, and return to the buffer base after a buffer write
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr_r <= `CFM_PTR_RESET;
      buf_touched_r <= 1'b0;
    end else if (wr_ev && first_r) begin
      ptr_r <= sh_r;
    end else if (wr_ev) begin
      ptr_r <= ptr_r + 8'h01;
      buf_touched_r <= buf_touched_r | in_buf;
    end else if (rd_done_ev && ptr_r != `CFM_PTR_STATUS) begin
      ptr_r <= ptr_r + 8'h01;
    end else if (stop_ev && buf_touched_r) begin
      ptr_r <= `CFM_BUF_FIRST;
      buf_touched_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Buffer decode and read data
  // ------------------------------------------------------------
  assign in_buf = (ptr_r >= `CFM_BUF_FIRST) && (ptr_r <= `CFM_BUF_LAST);
  assign bidx = 5'(ptr_r - `CFM_BUF_FIRST);
  assign len = buf_r[0];

  // Byte presented to a read
  always_comb begin
    rd_byte = `CFM_RD_FILL;
    if (ptr_r == `CFM_PTR_STATUS) begin
      rd_byte = 8'h00;
      rd_byte[`CFM_STAT_BUSY] = (st_r != ST_IDLE) && (st_r != ST_OUT);
      rd_byte[`CFM_STAT_INT] = irq_r;
    end else if (in_buf) begin
      if (st_r != ST_OUT) begin
        rd_byte = (bidx == 5'd0) ? `CFM_RD_EMPTY : `CFM_RD_FILL;
      end else if ({3'b000, bidx} < len) begin
        rd_byte = buf_r[bidx];
      end
    end
  end

  // ------------------------------------------------------------
  // Frame control
  // ------------------------------------------------------------
  // Host byte stored only from 07h or directly after the last one
  assign buf_wr = wr_ev && !first_r && in_buf && (st_r == ST_IDLE) && (rx_cnt_r == 5'd0)
    && ((bidx == 5'd0) || (hw_cnt_r != 5'd0 && bidx == hw_cnt_r));
  // Frame complete at its announced length or at the top register
  assign wr_done = buf_wr && ((bidx == 5'd0) ? (sh_r <= 8'h01) : ({3'b000, bidx} + 8'h01 >= len
    || bidx == 5'(`CFM_BUF_DEPTH - 1)));
  assign rx_take = rx_valid && rx_ready_r && (st_r == ST_IDLE);
  assign err_take = err_pend_r && (st_r == ST_IDLE) && (hw_cnt_r == 5'd0)
    && (rx_cnt_r == 5'd0) && !rx_take && !buf_wr;
  assign push_last = (idx_r == 5'(`CFM_BUF_DEPTH - 1)) || ({3'b000, idx_r} + 8'h01 >= len);
  assign push_data.last = push_last;
  assign push_data.data = buf_r[idx_r];

  // Buffer contents and ownership
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < `CFM_BUF_DEPTH; i++) begin
        buf_r[i] <= 8'h00;
      end
      st_r <= ST_IDLE;
      hw_cnt_r <= 5'd0;
      idx_r <= 5'd0;
      rx_cnt_r <= 5'd0;
      irq_r <= 1'b0;
      rd_started_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (rx_take) begin
            if (rx_cnt_r < `CFM_MAX_PARAMS) begin
              buf_r[rx_cnt_r + 5'd2] <= rx_in.data;
            end
            if (rx_in.last) begin
              buf_r[0] <= 8'(((rx_cnt_r < `CFM_MAX_PARAMS) ? rx_cnt_r : 5'd16) + 5'd3);
              buf_r[1] <= (rx_err && err_rpt_en) ? `CFM_SVC_IER : `CFM_SVC_IND;
              rx_cnt_r <= 5'd0;
              irq_r <= 1'b1;
              st_r <= ST_OUT;
            end else begin
              rx_cnt_r <= rx_cnt_r + 5'd1;
            end
          end else if (err_take) begin
            buf_r[0] <= `CFM_LEN_ERR;
            buf_r[1] <= `CFM_SVC_ERR;
            irq_r <= 1'b1;
            st_r <= ST_OUT;
          end else if (buf_wr) begin
            buf_r[bidx] <= sh_r;
            hw_cnt_r <= wr_done ? 5'd0 : bidx + 5'd1;
            if (wr_done) begin
              st_r <= ST_CHECK;
            end
          end else if (stop_ev) begin
            hw_cnt_r <= 5'd0;
          end
        end
        ST_CHECK: begin
          idx_r <= 5'd2;
          buf_r[0] <= `CFM_LEN_CNF;
          buf_r[1] <= `CFM_SVC_CNF;
          if (!line_on) begin
            buf_r[2] <= `CFM_RES_OFF;
            irq_r <= 1'b1;
            st_r <= ST_OUT;
          end else if (len < `CFM_MIN_LEN || buf_r[1] != `CFM_SVC_REQ) begin
            buf_r[2] <= `CFM_RES_BAD;
            irq_r <= 1'b1;
            st_r <= ST_OUT;
          end else begin
            buf_r[0] <= buf_r[0]; // Keep the request until sent
            buf_r[1] <= buf_r[1];
            st_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (fifo_in_ready) begin
            idx_r <= idx_r + 5'd1;
            if (push_last) begin
              st_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (res_valid) begin
            buf_r[0] <= `CFM_LEN_CNF;
            buf_r[1] <= `CFM_SVC_CNF;
            buf_r[2] <= res_code;
            irq_r <= 1'b1;
            st_r <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (rd_done_ev && in_buf && {3'b000, bidx} < len) begin
            rd_started_r <= 1'b1;
            if ({3'b000, bidx} + 8'h01 == len) begin
              irq_r <= 1'b0;
              rd_started_r <= 1'b0;
              st_r <= ST_IDLE;
            end
          end else if (stop_ev && rd_started_r) begin
            irq_r <= 1'b0;
            rd_started_r <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Pending error notice; a new event wins over delivery
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      err_pend_r <= 1'b0;
    end else if (err_evt && err_rpt_en) begin
      err_pend_r <= 1'b1;
    end else if (err_take) begin
      err_pend_r <= 1'b0;
    end
  end

  // Receive acceptance only while the buffer is free
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= (st_r == ST_IDLE) && (hw_cnt_r == 5'd0) && !buf_wr && !err_take
        && !(rx_take && rx_in.last);
    end
  end

  // ------------------------------------------------------------
  // Transmit FIFO toward the line engine
  // ------------------------------------------------------------
  cfm_fifo #(
    .W($bits(cfm_byte_t)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .in_data(push_data),
    .in_valid(st_r == ST_SEND),
    .in_ready(fifo_in_ready),
    .out_data(tx_out),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign irq = irq_r;
  assign rx_ready = rx_ready_r;
endmodule // cfm_top

/* testbench/cfm_host_model.sv */
// Host model: serial bus master on the frame window.
// Assumes a pull-up on the shared data wire in the bench.
`timescale 1ns/100ps

// ------------------------------------------------------------
// Bus master, 320 ns per bit, four 80 ns steps
// ------------------------------------------------------------
module cfm_host_model (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull,
  output logic [7:0] rd_byte,
  output int rd_cnt,
  output logic nak_seen
);
  localparam logic [6:0] ADDR = 7'h34; // Same as the design default
  // Idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_byte = 8'h00;
    nak_seen = 1'b0;
  end
  // One step: sample the wire, then move both pins
  task automatic step(input logic c, input logic d, output logic s);
    repeat (2) @(posedge clk_sys);
    s = sda_line;
    scl <= c;
    sda_pull <= !d;
  endtask
  // Pin pattern, MSB first; used for START and STOP
  task automatic wave(input logic [4:0] c, input logic [4:0] d);
    logic s;
    for (int i = 4; i >= 0; i--) step(c[i], d[i], s);
  endtask
  // One bit: long low phase lets the slave settle
  task automatic bitx(input logic d, output logic got);
    logic s;
    step(1'b0, d, s);
    step(1'b0, d, s);
    step(1'b1, d, got);
    step(1'b0, d, s);
  endtask
  // Byte plus acknowledge slot
  task automatic xbyte(input logic [7:0] w, input logic rd, input logic last,
                       output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(rd ? last : 1'b1, s);
    if (!rd && s) nak_seen <= 1'b1;
  endtask
  // Write: pointer first, then a contiguous run
  task automatic wr(input logic [7:0] fr[$]);
    logic [7:0] r;
    wave(5'b00110, 5'b11100);
    xbyte({ADDR, 1'b0}, 1'b0, 1'b0, r);
    foreach (fr[k]) xbyte(fr[k], 1'b0, 1'b0, r);
    wave(5'b00111, 5'b00011);
  endtask
  // Set pointer, STOP/START, then read n bytes
  task automatic rd(input logic [7:0] ptr, input int n);
    logic [7:0] r;
    wr({ptr});
    wave(5'b00110, 5'b11100);
    xbyte({ADDR, 1'b1}, 1'b0, 1'b0, r);
    for (int k = 0; k < n; k++) begin
      xbyte(8'hff, 1'b1, k == n - 1, r);
      rd_byte <= r;
      rd_cnt <= rd_cnt + 1;
    end
    wave(5'b00111, 5'b00011);
  endtask
endmodule // cfm_host_model

/* testbench/cfm_top_assertions.sv */
// Checker for the mailbox top: handshakes and interrupt timing.
// Assumes a bind onto cfm_top; sees only its ports.
`timescale 1ns/100ps

// ------------------------------------------------------------
// Port-level properties
// ------------------------------------------------------------
module cfm_top_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic irq,
  input wire logic err_rpt_en,
  input wire cfm_pkg::cfm_byte_t tx_out,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic res_valid,
  input wire cfm_pkg::cfm_byte_t rx_in,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  import cfm_pkg::*;
  logic scl_q_r; // Last host clock level
  logic [5:0] quiet_r; // Cycles since host clock moved
  // Host clock activity counter, saturating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      quiet_r <= 6'h00;
    end else begin
      scl_q_r <= scl_i;
      if (scl_i != scl_q_r) quiet_r <= 6'h00;
      else if (quiet_r != 6'h3f) quiet_r <= quiet_r + 6'h01;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rst_quiet_a: assert property (disable iff (1'b0) !rst_n |-> !irq && !tx_valid && !sda_oe)
    else $error("active in reset");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_out))
    else $error("tx moved in stall");
  tx_single_a: assert property (tx_valid && tx_ready && tx_out.last |=> !tx_valid [*8])
    else $error("second request at once");
  tx_after_a: assert property ($rose(tx_valid) |-> quiet_r < 6'd40)
    else $error("send without host write");
  res_irq_a: assert property (res_valid |=> irq)
    else $error("result not flagged");
  rx_irq_a: assert property (rx_valid && rx_ready && rx_in.last |=> irq)
    else $error("rx not flagged");
  irq_src_a: assert property ($rose(irq) |-> $past(res_valid) ||
    $past(rx_valid && rx_in.last) || quiet_r < 6'd40 || err_rpt_en)
    else $error("irq without cause");
  irq_fall_a: assert property ($fell(irq) |-> quiet_r < 6'd40)
    else $error("irq dropped without read");
  tx_end_c: cover property (tx_valid && tx_ready && tx_out.last);
  stall_c: cover property (tx_valid && !tx_ready [*4]);
  irq_drop_c: cover property ($fell(irq));
endmodule // cfm_top_assertions

bind cfm_top cfm_top_assertions chk (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl_i),
  .sda_oe(sda_oe), .irq(irq), .err_rpt_en(err_rpt_en), .tx_out(tx_out), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .res_valid(res_valid), .rx_in(rx_in), .rx_valid(rx_valid),
  .rx_ready(rx_ready));

/* testbench/tb_cfm_frame_mailbox.sv */
// Mailbox bench: host model on the pins, line engine stand-in.
// Assumes design, package, checker and host model are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_cfm_frame_mailbox;
  import cfm_pkg::*;
  // ------------------------------------------------------------
  // Signals and expectation queues
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n;
  logic line_on = 1'b1;
  logic err_rpt_en = 1'b0;
  logic tx_ready = 1'b0;
  logic res_valid = 1'b0;
  logic [7:0] res_code = 8'h00;
  cfm_byte_t rx_in = '0;
  logic rx_err = 1'b0;
  logic rx_valid = 1'b0;
  logic err_evt = 1'b0;
  logic stall = 1'b0; // Holds the line engine off
  logic scl, sda_pull, sda_o, sda_oe, irq, tx_valid, rx_ready, nak_seen;
  logic [7:0] rd_byte;
  cfm_byte_t tx_out;
  wire logic sda_line = !(sda_pull || sda_oe); // Pulled up
  int rd_cnt, bad_count, compares, seed = 32'h96ef, seen, res_wait;
  logic [8:0] txq[$]; // Expected line bytes
  logic [7:0] rdq[$]; // Expected host read bytes
  logic [8:0] ex;

  cfm_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq(irq), .line_on(line_on), .err_rpt_en(err_rpt_en), .tx_out(tx_out),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .res_valid(res_valid), .res_code(res_code),
    .rx_in(rx_in), .rx_err(rx_err), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .err_evt(err_evt));
  cfm_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull),
    .rd_byte(rd_byte), .rd_cnt(rd_cnt), .nak_seen(nak_seen));

  // 25 MHz system clock
  initial forever #20 clk_sys = ~clk_sys;

  // Line engine: random stalls, result pulse after the last byte
  always @(posedge clk_sys) begin
    tx_ready <= !stall && (($random(seed) & 3) != 0);
    res_valid <= (res_wait == 1);
    res_wait <= (tx_valid && tx_ready && tx_out.last) ? 6 : (res_wait > 0 ? res_wait - 1 : 0);
  end

  // Monitor: oldest note against each result
  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      ex = txq.pop_front();
      `CHK("tx_out", ex, tx_out)
    end
    if (rd_cnt != seen) begin
      seen = rd_cnt;
      ex = rdq.pop_front();
      `CHK("rd_byte", ex[7:0], rd_byte)
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bounded wait for an irq level
  task automatic wait_irq(input logic lvl);
    for (int t = 0; t < 3000 && irq !== lvl; t++) @(posedge clk_sys);
    `CHK("irq", lvl, irq)
  endtask
  task automatic expect_rd(input logic [7:0] ptr, input logic [7:0] e[$]);
    foreach (e[k]) rdq.push_back(e[k]);
    host.rd(ptr, e.size());
  endtask
  // Remote message, each byte held until taken
  task automatic rx_msg(input logic [7:0] m[$], input logic er);
    foreach (m[k]) begin
      rx_in <= '{last: k == m.size() - 1, data: m[k]};
      rx_err <= er;
      rx_valid <= 1'b1;
      @(posedge clk_sys);
      for (int t = 0; t < 100 && !rx_ready; t++) @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx_in <= ~rx_in;
  endtask
  // Transmit request, then read the confirmation
  task automatic req(input logic [7:0] len, input logic [7:0] svc, input int n,
                     input logic [7:0] code, input logic sends);
    logic [7:0] fr[$], b;
    fr = {8'h07, len, svc};
    for (int k = 0; k < n; k++) begin
      b = $random(seed);
      fr.push_back(b);
      if (sends) txq.push_back({k == n - 1, b});
    end
    res_code <= code;
    host.wr(fr);
    repeat (40) @(posedge clk_sys);
    stall <= 1'b0;
    wait_irq(1'b1);
    expect_rd(8'h07, {8'h03, 8'h01, code, 8'hff});
    wait_irq(1'b0);
  endtask
  task automatic pulse_err();
    err_evt <= 1'b1;
    @(posedge clk_sys);
    err_evt <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    expect_rd(8'h07, {8'h00, 8'hff});
    expect_rd(8'h00, {8'h00, 8'h00});
    host.wr({8'h07, 8'h05, 8'h00, 8'h11});
    repeat (300) @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    for (int i = 0; i < 9; i++) begin
      stall <= (i == 8);
      req(8'(3 + 2 * i), 8'h00, 1 + 2 * i, 8'((i % 8) ? 8'h7f + i : 0), 1'b1);
    end
    line_on <= 1'b0;
    req(8'h03, 8'h00, 1, 8'h80, 1'b0);
    line_on <= 1'b1;
    req(8'h04, 8'h05, 2, 8'h81, 1'b0);
    req(8'h02, 8'h00, 0, 8'h81, 1'b0);
    for (int j = 0; j < 3; j++) begin
      err_rpt_en <= (j != 2);
      rx_msg({8'h40, 8'h04}, j != 0);
      wait_irq(1'b1);
      expect_rd(8'h07, {8'h04, (j == 1) ? 8'h83 : 8'h81, 8'h40, 8'h04, 8'hff});
      wait_irq(1'b0);
    end
    rx_msg({8'h40, 8'h04}, 1'b0);
    wait_irq(1'b1);
    expect_rd(8'h07, {8'h04, 8'h81});
    wait_irq(1'b0);
    expect_rd(8'h07, {8'h00, 8'hff});
    pulse_err();
    repeat (300) @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    err_rpt_en <= 1'b1;
    pulse_err();
    wait_irq(1'b1);
    expect_rd(8'h07, {8'h02, 8'h82, 8'hff});
    wait_irq(1'b0);
    `CHK("ack", 1'b0, nak_seen)
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
endmodule // tb_cfm_frame_mailbox
